// ===== core/dra_defs.vh
`ifndef DRA_DEFS_VH
`define DRA_DEFS_VH

// command codes
`define DRA_CMD_COL_ADDR    8'h15
`define DRA_CMD_ROW_ADDR    8'h75
`define DRA_CMD_WRITE_RAM   8'h5c
`define DRA_CMD_READ_RAM    8'h5d
`define DRA_CMD_REMAP       8'ha0
`define DRA_CMD_START_LINE  8'ha1

// remap parameter field positions
`define DRA_RM_VERT         0
`define DRA_RM_COL_REV      1
`define DRA_RM_COLOR_REV    2
`define DRA_RM_NINE_BIT     3
`define DRA_RM_COM_REV      4
`define DRA_RM_COM_SPLIT    5
`define DRA_RM_DEPTH_HI     7
`define DRA_RM_DEPTH_LO     6

// colour-mode field encodings
`define DRA_DEPTH_256       2'h0
`define DRA_DEPTH_65K       2'h1
`define DRA_DEPTH_262K_M1   2'h2
`define DRA_DEPTH_262K_M2   2'h3

// geometry
`define DRA_LINES           132
`define DRA_HALF_LINES      66
`define DRA_ADDR_MAX        8'h83

// reset values
`define DRA_RST_START       8'h00
`define DRA_RST_END         8'h83
`define DRA_RST_REMAP       8'h00
`define DRA_RST_START_LINE  8'h00

`endif

// ===== core/dra_ptr.v
`default_nettype none

// next pointer pair after one ram access, window bounded
module dra_ptr #(
    parameter AW = 8
) (
    input  wire [AW-1:0] col_in,
    input  wire [AW-1:0] row_in,
    input  wire [AW-1:0] col_start_in,
    input  wire [AW-1:0] col_end_in,
    input  wire [AW-1:0] row_start_in,
    input  wire [AW-1:0] row_end_in,
    input  wire          vert_in,
    output reg  [AW-1:0] col_next_out,
    output reg  [AW-1:0] row_next_out
);
    reg col_last;   // pointer sits at (or past) column end
    reg row_last;   // pointer sits at (or past) row end

    // >= rather than == so a pointer left outside the window still wraps
    always @* begin
        col_last = (col_in >= col_end_in);
        row_last = (row_in >= row_end_in);
        col_next_out = col_in;
        row_next_out = row_in;
        if (!vert_in) begin
            if (col_last) begin
                col_next_out = col_start_in;
                row_next_out = row_last ? row_start_in : row_in + 1'b1;
            end else begin
                col_next_out = col_in + 1'b1;
            end
        end else begin
            if (row_last) begin
                row_next_out = row_start_in;
                col_next_out = col_last ? col_start_in : col_in + 1'b1;
            end else begin
                row_next_out = row_in + 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ===== core/dra_row_map.v
`default_nettype none
`include "dra_defs.vh"

// common pin to display ram row, for the scan side
module dra_row_map #(
    parameter MUX_RATIO = `DRA_LINES
) (
    input  wire [7:0] pin_in,        // physical common pin index
    input  wire [7:0] start_line_in, // first ram row shown
    input  wire       com_rev_in,    // reverse scan direction
    input  wire       split_in,      // odd/even pin split
    output reg  [7:0] row_out,       // ram row for this pin
    output reg        valid_out      // pin within multiplex ratio
);
    reg [8:0] common_output;   // logical common line
    reg [8:0] sum;   // start line plus line, before modulo

    always @* begin
        // split: first half of pins carry even lines, second half odd
        if (split_in) begin
            if (pin_in < `DRA_HALF_LINES)
                common_output = {pin_in, 1'b0};
            else
                common_output = {pin_in - 8'd`DRA_HALF_LINES, 1'b1};
        end else begin
            common_output = {1'b0, pin_in};
        end
        valid_out = (common_output < MUX_RATIO);
        if (com_rev_in && valid_out)
            common_output = 9'd`DRA_LINES - (9'd`DRA_LINES - MUX_RATIO) - 9'd1 - common_output;
        sum = {1'b0, start_line_in} + common_output;
        if (sum >= `DRA_LINES)
            sum = sum - 9'd`DRA_LINES;
        row_out = sum[7:0];
    end
endmodule

`default_nettype wire

// ===== core/dra_top.v
// Operation
// - column command sets window, loads column pointer
// - row command sets window, loads row pointer
// - column end wraps pointer to column start
// - row end wraps pointer to row start
// - horizontal mode wraps both at window end
// - write-ram command streams data until next command
// - read-ram command streams reads until next command
// - horizontal mode: column steps, row on wrap
// - vertical mode: row steps, column on wrap
// - column mapping bit reverses segment order
// - colour remap bit swaps A and C
// - interface bit picks 8/16 or 9/18 format
// - common remap bit reverses common scan
// - split bit selects odd/even common pin layout
// - two-bit field selects 262k, 65k, 256 colours
// - 262k on 16-bit: two words or 3-for-2
// - other ports treat both 262k modes alike
// - start line command loads 0 to 131
// - only data accesses advance the pointer
`default_nettype none
`include "dra_defs.vh"

module dra_top #(
    parameter MUX_RATIO = `DRA_LINES
) (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire        wr_stb_in,      // host write strobe, one cycle
    input  wire        rd_stb_in,      // host read strobe, one cycle
    input  wire        dc_in,          // high: data, low: command/status
    input  wire [17:0] data_in,        // host write word
    input  wire        host_wide_in,   // parallel port is 16/18 bits wide
    input  wire [17:0] ram_rdata_in,   // display_ram read data, one cycle
    input  wire [7:0]  scan_pin_in,    // common pin being scanned
    input  wire [7:0]  scan_seg_in,    // segment column being driven
    output reg         ram_we_out,
    output reg         ram_re_out,
    output reg  [7:0]  ram_col_out,
    output reg  [7:0]  ram_row_out,
    output reg  [17:0] ram_wdata_out,
    output reg  [17:0] rd_data_out,
    output reg         rd_valid_out,
    output reg  [7:0]  remap_out,      // remap/colour-depth byte as held
    output reg  [7:0]  start_line_out,
    output reg  [7:0]  scan_row_out,   // display_ram row for common_output
    output reg         scan_valid_out,
    output reg  [7:0]  scan_col_out    // display_ram column for segment_output
);
    // interpreter states
    localparam ST_IDLE  = 2'h0;
    localparam ST_PARAM = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_READ  = 2'h3;

    // 256 colours: rrrgggbb widened to 6 bits per component
    function [17:0] fmt256;
        input [7:0] w;
        begin
            fmt256 = {w[7:5], w[7:5], w[4:2], w[4:2], w[1:0], w[1:0], w[1:0]};
        end
    endfunction

    // 65k colours: 5/6/5 widened, msbs repeated into the lsb
    function [17:0] fmt65k;
        input [15:0] w;
        begin
            fmt65k = {w[15:11], w[15], w[10:5], w[4:0], w[4]};
        end
    endfunction

    reg        rst_meta_reg;   // reset release synchroniser
    reg        rst_sync_reg;
    wire       rst_n = rst_sync_reg;

    reg [1:0]  state_reg;
    reg [7:0]  cmd_reg;        // command awaiting parameters
    reg        pidx_reg;       // parameter index
    reg [7:0]  p0_reg;         // first parameter held
    reg [7:0]  col_start_reg;
    reg [7:0]  col_end_reg;
    reg [7:0]  row_start_reg;
    reg [7:0]  row_end_reg;
    reg [7:0]  col_ptr_reg;
    reg [7:0]  row_ptr_reg;
    reg [1:0]  phase_reg;      // word position inside a pixel group
    reg [17:0] part_reg;       // partial pixel bits
    reg        rd_pend_reg;    // ram read issued last cycle

    wire [7:0] col_adv;        // pointer after one access
    wire [7:0] row_adv;
    wire [7:0] map_row;
    wire       map_valid;

    wire       data_wr = wr_stb_in & dc_in;
    wire       data_rd = rd_stb_in & dc_in;
    wire       cmd_wr  = wr_stb_in & ~dc_in;
    wire       stat_rd = rd_stb_in & ~dc_in;
    wire [1:0] depth   = remap_out[`DRA_RM_DEPTH_HI:`DRA_RM_DEPTH_LO];
    wire       nine    = remap_out[`DRA_RM_NINE_BIT];

    reg        pix_done;       // a pixel is complete on this word
    reg [17:0] pix_abc;        // completed pixel, A in the top bits
    reg [17:0] part_next;
    reg [1:0]  phase_next;

    // reset: asserted at once, released on the clock
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    dra_ptr #(
        .AW(8)
    ) u_ptr (
        .col_in      (col_ptr_reg),
        .row_in      (row_ptr_reg),
        .col_start_in(col_start_reg),
        .col_end_in  (col_end_reg),
        .row_start_in(row_start_reg),
        .row_end_in  (row_end_reg),
        .vert_in     (remap_out[`DRA_RM_VERT]),
        .col_next_out(col_adv),
        .row_next_out(row_adv)
    );

    dra_row_map #(
        .MUX_RATIO(MUX_RATIO)
    ) u_map (
        .pin_in       (scan_pin_in),
        .start_line_in(start_line_out),
        .com_rev_in   (remap_out[`DRA_RM_COM_REV]),
        .split_in     (remap_out[`DRA_RM_COM_SPLIT]),
        .row_out      (map_row),
        .valid_out    (map_valid)
    );

    // pixel assembly from host words; the word layout depends on port and depth
    always @* begin
        pix_done   = 1'b0;
        pix_abc    = 18'h00000;
        part_next  = part_reg;
        phase_next = phase_reg + 2'h1;
        if (depth == `DRA_DEPTH_256) begin
            pix_done   = 1'b1;
            pix_abc    = fmt256(data_in[7:0]);
            phase_next = 2'h0;
        end else if (depth == `DRA_DEPTH_65K) begin
            if (host_wide_in) begin
                pix_done   = 1'b1;
                pix_abc    = fmt65k(data_in[15:0]);
                phase_next = 2'h0;
            end else if (phase_reg == 2'h0) begin
                part_next = {10'h000, data_in[7:0]};                    // high byte first
            end else begin
                pix_done   = 1'b1;
                pix_abc    = fmt65k({part_reg[7:0], data_in[7:0]});
                phase_next = 2'h0;
            end
        end else if (host_wide_in && !nine && depth == `DRA_DEPTH_262K_M2) begin
            // three 16-bit words carry two pixels
            case (phase_reg)
                2'h0: begin
                    part_next = {data_in[15:10], data_in[7:2], 6'h00};
                end
                2'h1: begin
                    pix_done  = 1'b1;
                    pix_abc   = {part_reg[17:6], data_in[15:10]};
                    part_next = {data_in[7:2], 12'h000};
                end
                default: begin
                    pix_done   = 1'b1;
                    pix_abc    = {part_reg[17:12], data_in[15:10], data_in[7:2]};
                    phase_next = 2'h0;
                end
            endcase
        end else if (host_wide_in && !nine) begin
            // one pixel in two 16-bit words
            if (phase_reg == 2'h0) begin
                part_next = {data_in[7:2], 12'h000};
            end else begin
                pix_done   = 1'b1;
                pix_abc    = {part_reg[17:12], data_in[15:10], data_in[7:2]};
                phase_next = 2'h0;
            end
        end else if (host_wide_in) begin
            // 18-bit port: whole pixel per word, modes alike
            pix_done   = 1'b1;
            pix_abc    = data_in;
            phase_next = 2'h0;
        end else if (nine) begin
            // 9-bit port: two words per pixel, modes alike
            if (phase_reg == 2'h0) begin
                part_next = {data_in[8:0], 9'h000};
            end else begin
                pix_done   = 1'b1;
                pix_abc    = {part_reg[17:9], data_in[8:0]};
                phase_next = 2'h0;
            end
        end else begin
            // 8-bit or serial: three bytes per pixel, modes alike
            case (phase_reg)
                2'h0: begin
                    part_next = {data_in[7:2], 12'h000};
                end
                2'h1: begin
                    part_next = {part_reg[17:12], data_in[7:2], 6'h00};
                end
                default: begin
                    pix_done   = 1'b1;
                    pix_abc    = {part_reg[17:6], data_in[7:2]};
                    phase_next = 2'h0;
                end
            endcase
        end
    end

    // command interpreter, pointers and ram port
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            cmd_reg        <= 8'h00;
            pidx_reg       <= 1'b0;
            p0_reg         <= 8'h00;
            col_start_reg  <= `DRA_RST_START;
            col_end_reg    <= `DRA_RST_END;
            row_start_reg  <= `DRA_RST_START;
            row_end_reg    <= `DRA_RST_END;
            col_ptr_reg    <= `DRA_RST_START;
            row_ptr_reg    <= `DRA_RST_START;
            phase_reg      <= 2'h0;
            part_reg       <= 18'h00000;
            rd_pend_reg    <= 1'b0;
            remap_out      <= `DRA_RST_REMAP;
            start_line_out <= `DRA_RST_START_LINE;
            ram_we_out     <= 1'b0;
            ram_re_out     <= 1'b0;
            ram_col_out    <= 8'h00;
            ram_row_out    <= 8'h00;
            ram_wdata_out  <= 18'h00000;
            rd_data_out    <= 18'h00000;
            rd_valid_out   <= 1'b0;
        end else begin
            // strobes last one cycle
            ram_we_out   <= 1'b0;
            ram_re_out   <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_pend_reg  <= 1'b0;

            // ram answers one cycle after the read was issued
            if (rd_pend_reg) begin
                rd_data_out  <= ram_rdata_in;
                rd_valid_out <= 1'b1;
            end

            // status reads answer zero and leave the pointer alone
            if (stat_rd) begin
                rd_data_out  <= 18'h00000;
                rd_valid_out <= 1'b1;
            end

            if (cmd_wr) begin
                // any command ends a stream and restarts pixel grouping
                phase_reg <= 2'h0;
                pidx_reg  <= 1'b0;
                cmd_reg   <= data_in[7:0];
                case (data_in[7:0])
                    `DRA_CMD_COL_ADDR:   state_reg <= ST_PARAM;
                    `DRA_CMD_ROW_ADDR:   state_reg <= ST_PARAM;
                    `DRA_CMD_REMAP:      state_reg <= ST_PARAM;
                    `DRA_CMD_START_LINE: state_reg <= ST_PARAM;
                    `DRA_CMD_WRITE_RAM:  state_reg <= ST_WRITE;
                    `DRA_CMD_READ_RAM:   state_reg <= ST_READ;
                    default:             state_reg <= ST_IDLE;          // other blocks' commands
                endcase
            end else begin
                case (state_reg)
                    ST_PARAM: begin
                        if (data_wr) begin
                            pidx_reg <= 1'b1;
                            p0_reg   <= data_in[7:0];
                            if (cmd_reg == `DRA_CMD_REMAP) begin
                                remap_out <= data_in[7:0];
                                state_reg <= ST_IDLE;
                            end else if (cmd_reg == `DRA_CMD_START_LINE) begin
                                // values past the last row are dropped
                                if (data_in[7:0] <= `DRA_ADDR_MAX)
                                    start_line_out <= data_in[7:0];
                                state_reg <= ST_IDLE;
                            end else if (pidx_reg) begin
                                state_reg <= ST_IDLE;
                                if (cmd_reg == `DRA_CMD_COL_ADDR) begin
                                    col_start_reg <= p0_reg;
                                    col_end_reg   <= data_in[7:0];
                                    col_ptr_reg   <= p0_reg;
                                end else begin
                                    row_start_reg <= p0_reg;
                                    row_end_reg   <= data_in[7:0];
                                    row_ptr_reg   <= p0_reg;
                                end
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (data_wr) begin
                            phase_reg <= phase_next;
                            part_reg  <= part_next;
                            if (pix_done) begin
                                ram_we_out  <= 1'b1;
                                ram_col_out <= col_ptr_reg;
                                ram_row_out <= row_ptr_reg;
                                if (remap_out[`DRA_RM_COLOR_REV])
                                    ram_wdata_out <= {pix_abc[5:0], pix_abc[11:6],
                                                      pix_abc[17:12]};
                                else
                                    ram_wdata_out <= pix_abc;
                                col_ptr_reg <= col_adv;
                                row_ptr_reg <= row_adv;
                            end
                        end
                    end
                    ST_READ: begin
                        if (data_rd) begin
                            ram_re_out  <= 1'b1;
                            ram_col_out <= col_ptr_reg;
                            ram_row_out <= row_ptr_reg;
                            rd_pend_reg <= 1'b1;
                            col_ptr_reg <= col_adv;
                            row_ptr_reg <= row_adv;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // scan-side address mapping, registered for the drivers
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scan_row_out   <= 8'h00;
            scan_valid_out <= 1'b0;
            scan_col_out   <= 8'h00;
        end else begin
            scan_row_out   <= map_row;
            scan_valid_out <= map_valid;
            if (remap_out[`DRA_RM_COL_REV])
                scan_col_out <= `DRA_ADDR_MAX - scan_seg_in;
            else
                scan_col_out <= scan_seg_in;
        end
    end
endmodule

`default_nettype wire

// ===== verif/display_ram_address_control_test.sv
`default_nettype none
`include "dra_defs.vh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module display_ram_address_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        wr_stb_in = 1'b0;
    logic        rd_stb_in = 1'b0;
    logic        dc_in = 1'b0;
    logic [17:0] data_in = 18'h0;
    logic [7:0]  scan_pin_in = 8'h0;
    logic [7:0]  scan_seg_in = 8'h0;
    wire  [17:0] ram_rdata, ram_wdata, rd_data_out;
    wire  [7:0]  ram_col, ram_row, remap_out, start_line_out, scan_row_out, scan_col_out;
    wire         ram_we, ram_re, rd_valid_out;
    logic [7:0]  mode_tab [4] = '{8'h00, 8'h01, 8'h8c, 8'hc8}; // 256, vertical, 262k x2
    logic [7:0]  scan_tab [3] = '{8'hc8, 8'h12, 8'h20};        // plain, reversed, split
    logic [7:0]  srow_tab [3] = '{8'd4, 8'd125, 8'd9};
    logic [7:0]  scol_tab [3] = '{8'd7, 8'd124, 8'd7};
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    always #2 clk_in = ~clk_in;
    dra_top dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
        .dc_in(dc_in), .data_in(data_in), .host_wide_in(1'b1), .ram_rdata_in(ram_rdata),
        .scan_pin_in(scan_pin_in), .scan_seg_in(scan_seg_in), .ram_we_out(ram_we),
        .ram_re_out(ram_re), .ram_col_out(ram_col), .ram_row_out(ram_row),
        .ram_wdata_out(ram_wdata), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .remap_out(remap_out), .start_line_out(start_line_out), .scan_row_out(scan_row_out),
        .scan_valid_out(), .scan_col_out(scan_col_out)
    );
    dra_ram_model ram (
        .clk_in(clk_in), .we_in(ram_we), .re_in(ram_re), .col_in(ram_col), .row_in(ram_row),
        .wdata_in(ram_wdata), .rdata_out(ram_rdata)
    );
    // one host word, strobe high for exactly one edge
    task automatic wr(input logic d, input logic [17:0] v);
        @(posedge clk_in);
        #1;
        dc_in = d;
        data_in = v;
        wr_stb_in = 1'b1;
        @(posedge clk_in);
        #1;
        wr_stb_in = 1'b0;
    endtask
    task automatic rd(input logic d);
        @(posedge clk_in);
        #1;
        dc_in = d;
        rd_stb_in = 1'b1;
        @(posedge clk_in);
        #1;
        rd_stb_in = 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] a);
        wr(1'b0, {10'h0, c});
        wr(1'b1, {10'h0, a});
    endtask
    // window columns 2..4, rows 1..2
    task automatic win();
        cmd(`DRA_CMD_COL_ADDR, 8'd2);
        wr(1'b1, 18'd4);
        cmd(`DRA_CMD_ROW_ADDR, 8'd1);
        wr(1'b1, 18'd2);
    endtask
    // expected pointer move after one access
    task automatic step(input logic v, inout logic [7:0] c, inout logic [7:0] r);
        if (!v) begin
            if (c == 8'd4) begin
                c = 8'd2;
                r = (r == 8'd2) ? 8'd1 : r + 8'd1;
            end else c = c + 8'd1;
        end else if (r == 8'd2) begin
            r = 8'd1;
            c = (c == 8'd4) ? 8'd2 : c + 8'd1;
        end else r = r + 8'd1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, whole run needs well under this
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        logic [7:0]  c;
        logic [7:0]  r;
        logic [17:0] d;
        logic [17:0] x;
        repeat (5) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        rd(1'b1);
        `CHK("ram_re idle", 1'b0, ram_re)
        wr(1'b1, 18'h1);
        `CHK("ram_we idle", 1'b0, ram_we)
        // both increments and the 256 and 262k colour modes through a wrapping stream
        foreach (mode_tab[m]) begin
            cmd(`DRA_CMD_REMAP, mode_tab[m]);
            `CHK("remap", mode_tab[m], remap_out)
            win();
            wr(1'b0, {10'h0, `DRA_CMD_WRITE_RAM});
            c = 8'd2;
            r = 8'd1;
            for (int i = 0; i < 7; i++) begin
                d = {6'(i + 1), 6'h2a, 6'h15};
                x = mode_tab[m][2] ? {d[5:0], d[11:6], d[17:12]} : d;
                wr(1'b1, d);
                `CHK("we", 1'b1, ram_we)
                `CHK("col", c, ram_col)
                `CHK("row", r, ram_row)
                if (mode_tab[m][3]) `CHK("pix", x, ram_wdata)
                step(mode_tab[m][0], c, r);
            end
        end
        // unknown command ends the stream
        wr(1'b0, 18'he3);
        wr(1'b1, 18'h5);
        `CHK("we after cmd", 1'b0, ram_we)
        win();
        wr(1'b0, {10'h0, `DRA_CMD_READ_RAM});
        rd(1'b1); // dummy read, discarded
        for (int k = 1; k < 4; k++) begin
            if (k == 3) begin
                rd(1'b0);
                `CHK("status", 18'h0, rd_data_out)
            end
            rd(1'b1);
            @(posedge clk_in);
            #1;
            `CHK("rd_valid", 1'b1, rd_valid_out)
            `CHK("rd_data", {6'(k + 1), 6'h2a, 6'h15}, rd_data_out)
        end
        cmd(`DRA_CMD_START_LINE, 8'd131);
        cmd(`DRA_CMD_START_LINE, 8'd132);
        `CHK("start", 8'd131, start_line_out)
        scan_pin_in = 8'd5;
        scan_seg_in = 8'd7;
        foreach (scan_tab[j]) begin
            cmd(`DRA_CMD_REMAP, scan_tab[j]);
            repeat (2) @(posedge clk_in);
            #1;
            `CHK("scan_row", srow_tab[j], scan_row_out)
            `CHK("scan_col", scol_tab[j], scan_col_out)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== verif/dra_asserts.sv
`default_nettype none
// port-level rules of the ram access block
module dra_chk (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        wr_stb_in,
    input wire logic        rd_stb_in,
    input wire logic        dc_in,
    input wire logic [17:0] data_in,
    input wire logic [17:0] ram_rdata_in,
    input wire logic [7:0]  scan_pin_in,
    input wire logic [7:0]  scan_seg_in,
    input wire logic        ram_we_out,
    input wire logic        ram_re_out,
    input wire logic [17:0] rd_data_out,
    input wire logic        rd_valid_out,
    input wire logic [7:0]  remap_out,
    input wire logic [7:0]  start_line_out,
    input wire logic [7:0]  scan_row_out,
    input wire logic [7:0]  scan_col_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] live_reg; // two stages past the design's release so $past never sees reset-time values
    // follows the two-stage reset release inside the design
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) live_reg <= 4'h0;
        else live_reg <= {live_reg[2:0], 1'b1};
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!live_reg[3]);
    property p_cmd_quiet;
        wr_stb_in && !dc_in |=> !ram_we_out && !ram_re_out;
    endproperty
    a_cmd_quiet: assert property (p_cmd_quiet)
        else $error("command word touched the ram");
    property p_status;
        rd_stb_in && !dc_in |=> rd_valid_out && rd_data_out == 18'h0 && !ram_re_out;
    endproperty
    a_status: assert property (p_status)
        else $error("status read wrong");
    property p_rd_ret;
        ram_re_out |=> rd_valid_out && rd_data_out == $past(ram_rdata_in);
    endproperty
    a_rd_ret: assert property (p_rd_ret)
        else $error("read data not returned");
    property p_we_cause;
        ram_we_out |-> $past(wr_stb_in) && $past(dc_in);
    endproperty
    a_we_cause: assert property (p_we_cause)
        else $error("ram write without data word");
    property p_re_cause;
        ram_re_out |-> $past(rd_stb_in) && $past(dc_in);
    endproperty
    a_re_cause: assert property (p_re_cause)
        else $error("ram read without data read");
    property p_start;
        $changed(start_line_out) |-> start_line_out <= 8'h83 && $past(wr_stb_in)
            && $past(dc_in) && start_line_out == $past(data_in[7:0]);
    endproperty
    a_start: assert property (p_start)
        else $error("start line load wrong");
    property p_remap;
        $changed(remap_out) |-> $past(wr_stb_in) && $past(dc_in)
            && remap_out == $past(data_in[7:0]);
    endproperty
    a_remap: assert property (p_remap)
        else $error("remap load wrong");
    property p_scan_row;
        $past(remap_out[5:4]) == 2'h0 && $past(scan_pin_in) < 8'd132 |-> scan_row_out
            == ({1'b0, $past(start_line_out)} + {1'b0, $past(scan_pin_in)}) % 9'd132;
    endproperty
    a_scan_row: assert property (p_scan_row)
        else $error("scan row wrong");
    property p_scan_col;
        scan_col_out == ($past(remap_out[1]) ? 8'd131 - $past(scan_seg_in) : $past(scan_seg_in));
    endproperty
    a_scan_col: assert property (p_scan_col)
        else $error("scan column wrong");
    c_write: cover property (ram_we_out);
    c_read: cover property (ram_re_out ##1 rd_valid_out);
    c_rev: cover property (remap_out[1] && start_line_out == 8'h83);
endmodule
bind dra_top dra_chk u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
    .dc_in(dc_in), .data_in(data_in), .ram_rdata_in(ram_rdata_in),
    .scan_pin_in(scan_pin_in), .scan_seg_in(scan_seg_in), .ram_we_out(ram_we_out),
    .ram_re_out(ram_re_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .remap_out(remap_out), .start_line_out(start_line_out),
    .scan_row_out(scan_row_out), .scan_col_out(scan_col_out)
);
`default_nettype wire

// ===== verif/dra_ram_model.sv
`default_nettype none
// display_ram stand-in, read answered in the pulse cycle
module dra_ram_model (
    input  wire logic        clk_in,
    input  wire logic        we_in,
    input  wire logic        re_in,
    input  wire logic [7:0]  col_in,
    input  wire logic [7:0]  row_in,
    input  wire logic [17:0] wdata_in,
    output wire logic [17:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] mem [0:65535]; // one word per row/column pair
    logic [17:0] last_reg = 18'h0; // last word handed out
    // store writes, remember last read
    always @(posedge clk_in) begin
        if (we_in) mem[{row_in, col_in}] <= wdata_in;
        if (re_in) last_reg <= mem[{row_in, col_in}];
    end
    // inverse when idle so stale data never looks valid
    assign rdata_out = re_in ? mem[{row_in, col_in}] : ~last_reg;
endmodule
`default_nettype wire
